// ===== include/pwm_ctrl_pkg.sv
package pwm_ctrl_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [3:0] addr_update_control = 4'h0;
  localparam logic [3:0] addr_deadtime_config = 4'h1;
  localparam logic [3:0] addr_trigger_compare = 4'h2;
  localparam logic [3:0] addr_duty_buffer = 4'h3;
  localparam logic [3:0] addr_period_buffer = 4'h4;
  localparam logic [3:0] addr_override = 4'h5;
  localparam logic [3:0] addr_status = 4'h6;
  localparam logic [3:0] addr_duty_active = 4'h7;
  localparam logic [3:0] addr_deadtime_stat = 4'h8;

  // ****************************************
  // Field positions and masks
  // ****************************************
  localparam int postscale_lsb = 8;
  localparam int iue_bit = 2;
  localparam int override_sync_sel_bit = 1;
  localparam int update_block_bit = 0;
  localparam logic [15:0] update_control_mask = 16'h0f07;
  localparam logic [15:0] trigger_compare_mask = 16'hffff;
  localparam int dtb_ps_lsb = 14;
  localparam int dtb_cnt_lsb = 8;
  localparam int dta_ps_lsb = 6;
  localparam int dta_cnt_lsb = 0;
  localparam logic [15:0] reg_reset = 16'h0000;
  localparam logic [31:0] unmapped_read = 32'h0000_0000;

  // ****************************************
  // Timing
  // ****************************************
  localparam int clk_mhz = 200;
  localparam int tcy_ns = 10;
  localparam int tcy_cycles = (tcy_ns * clk_mhz + 999) / 1000;

  typedef struct packed {
    logic [3:0] postscale;
    logic immediate_update_enable;
    logic override_sync_sel;
    logic update_block;
  } update_ctrl_type;

  typedef struct packed {
    logic [1:0] prescale;
    logic [5:0] count;
  } deadtime_unit_type;

  typedef enum logic [1:0] {
    dt_idle = 2'b00,
    dt_run = 2'b01,
    dt_done = 2'b11
  } dt_state_type;

endpackage : pwm_ctrl_pkg

// ===== design/deadtime_unit.sv
`timescale 1ns/10ps
`default_nettype none
module deadtime_unit
  import pwm_ctrl_pkg::*;
#(
  parameter int tcy_div = tcy_cycles
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic tcy_tick,
  input wire deadtime_unit_type cfg,
  input wire logic start,
  output logic busy
);

  logic [2:0] pre_cnt;
  logic [5:0] dt_cnt;
  dt_state_type state;
  wire logic [2:0] pre_max = 3'((1 << cfg.prescale) - 1);
  wire logic dt_tick = tcy_tick && (pre_cnt == pre_max);

  // ****************************************
  // Prescaled dead-time counter
  // ****************************************
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state <= dt_idle;
      pre_cnt <= 3'h0;
      dt_cnt <= 6'h00;
    end else begin
      case (state)
        dt_idle: begin
          pre_cnt <= 3'h0;
          dt_cnt <= cfg.count;
          if (start && cfg.count != 6'h00) begin
            state <= dt_run;
          end
        end
        dt_run: begin
          if (tcy_tick) begin
            pre_cnt <= dt_tick ? 3'h0 : pre_cnt + 3'h1;
          end
          if (dt_tick) begin
            dt_cnt <= dt_cnt - 6'h01;
            if (dt_cnt == 6'h01) begin
              state <= dt_done;
            end
          end
        end
        default: begin
          state <= dt_idle;
        end
      endcase
    end
  end

  assign busy = (state == dt_run);

endmodule : deadtime_unit
`default_nettype wire

// ===== design/pwm_update_ctrl.sv
// Our own choices: the Avalon-MM register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module pwm_update_ctrl
  import pwm_ctrl_pkg::*;
#(
  parameter int tcy_div = tcy_cycles
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [15:0] pwm_timebase_count,
  input wire logic timebase_period_match,
  input wire logic deadtime_a_start,
  input wire logic deadtime_b_start,
  output logic special_event_trigger,
  output logic [15:0] duty_active,
  output logic [15:0] period_active,
  output logic [15:0] override_pins,
  output logic deadtime_a_busy,
  output logic deadtime_b_busy
);

  update_ctrl_type pwm_update_control;
  deadtime_unit_type deadtime_a;
  deadtime_unit_type deadtime_b;
  logic [15:0] trigger_compare_value;
  logic [15:0] duty_buffer;
  logic [15:0] period_buffer;
  logic [15:0] override_control_reg;
  logic [3:0] post_cnt;
  logic [15:0] prev_timebase;
  logic [2:0] tcy_cnt;
  logic duty_pending;
  logic override_pending;
  logic read_done;

  // ****************************************
  // Bus decode
  // ****************************************
  function automatic logic [15:0] merge16(input logic [15:0] old,
      input logic [31:0] wd, input logic [3:0] be, input logic [15:0] msk);
    logic [15:0] val;
    val = old;
    if (be[0]) val[7:0] = wd[7:0];
    if (be[1]) val[15:8] = wd[15:8];
    merge16 = val & msk;
  endfunction : merge16

  wire logic wr_upd = avs_write && avs_address == addr_update_control;
  wire logic wr_dt = avs_write && avs_address == addr_deadtime_config;
  wire logic wr_cmp = avs_write && avs_address == addr_trigger_compare;
  wire logic wr_duty = avs_write && avs_address == addr_duty_buffer;
  wire logic wr_per = avs_write && avs_address == addr_period_buffer;
  wire logic wr_ovr = avs_write && avs_address == addr_override;

  wire logic [15:0] upd_word = {4'h0, pwm_update_control.postscale, 5'h00,
      pwm_update_control.immediate_update_enable,
      pwm_update_control.override_sync_sel,
      pwm_update_control.update_block};
  wire logic [15:0] dt_word = {deadtime_b, deadtime_a};
  wire logic [15:0] upd_new = merge16(upd_word, avs_writedata,
      avs_byteenable, update_control_mask);
  wire logic [15:0] dt_new = merge16(dt_word, avs_writedata,
      avs_byteenable, 16'hffff);
  wire logic [15:0] status_word = {12'h000, deadtime_b_busy,
      deadtime_a_busy, override_pending, duty_pending};

  logic [31:0] next_readdata;
  always_comb begin
    if (avs_address == addr_update_control) begin
      next_readdata = {16'h0000, upd_word};
    end else if (avs_address == addr_deadtime_config) begin
      next_readdata = {16'h0000, dt_word};
    end else if (avs_address == addr_trigger_compare) begin
      next_readdata = {16'h0000, trigger_compare_value};
    end else if (avs_address == addr_duty_buffer) begin
      next_readdata = {16'h0000, duty_buffer};
    end else if (avs_address == addr_period_buffer) begin
      next_readdata = {16'h0000, period_buffer};
    end else if (avs_address == addr_override) begin
      next_readdata = {16'h0000, override_control_reg};
    end else if (avs_address == addr_status) begin
      next_readdata = {16'h0000, status_word};
    end else if (avs_address == addr_duty_active) begin
      next_readdata = {16'h0000, duty_active};
    end else if (avs_address == addr_deadtime_stat) begin
      next_readdata = {16'h0000, period_active};
    end else begin
      next_readdata = unmapped_read;
    end
  end

  // Writes finish at once; reads take one wait cycle for registered data
  assign avs_waitrequest = avs_read && !read_done;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      read_done <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else begin
      read_done <= avs_read && !read_done;
      if (avs_read && !read_done) begin
        avs_readdata <= next_readdata;
      end
    end
  end

  // ****************************************
  // Control registers
  // ****************************************
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pwm_update_control <= '0;
      deadtime_a <= '0;
      deadtime_b <= '0;
      trigger_compare_value <= reg_reset;
      duty_buffer <= reg_reset;
      period_buffer <= reg_reset;
      override_control_reg <= reg_reset;
    end else begin
      if (wr_upd) begin
        pwm_update_control <= {upd_new[postscale_lsb +: 4],
            upd_new[iue_bit], upd_new[override_sync_sel_bit], upd_new[update_block_bit]};
      end
      if (wr_dt) begin
        deadtime_b <= dt_new[15:8];
        deadtime_a <= dt_new[7:0];
      end
      if (wr_cmp) begin
        trigger_compare_value <= merge16(trigger_compare_value,
            avs_writedata, avs_byteenable, trigger_compare_mask);
      end
      if (wr_duty) begin
        duty_buffer <= merge16(duty_buffer, avs_writedata,
            avs_byteenable, 16'hffff);
      end
      if (wr_per) begin
        period_buffer <= merge16(period_buffer, avs_writedata,
            avs_byteenable, 16'hffff);
      end
      if (wr_ovr) begin
        override_control_reg <= merge16(override_control_reg,
            avs_writedata, avs_byteenable, 16'hffff);
      end
    end
  end

  // ****************************************
  // Instruction cycle tick
  // ****************************************
  wire logic tcy_tick = (tcy_cnt == 3'(tcy_div - 1));

  always_ff @(posedge clk) begin
    if (!nrst) begin
      tcy_cnt <= 3'h0;
    end else begin
      tcy_cnt <= tcy_tick ? 3'h0 : tcy_cnt + 3'h1;
    end
  end

  // ****************************************
  // Buffer transfers and override timing
  // ****************************************
  wire logic ub = pwm_update_control.update_block;
  wire logic duty_now = pwm_update_control.immediate_update_enable ?
      (duty_pending && !ub) :
      (duty_pending && !ub && timebase_period_match);
  wire logic ovr_now = pwm_update_control.override_sync_sel ?
      (override_pending && timebase_period_match) :
      (override_pending && tcy_tick);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      duty_pending <= 1'b0;
      override_pending <= 1'b0;
      duty_active <= reg_reset;
      period_active <= reg_reset;
      override_pins <= reg_reset;
    end else begin
      // A new write wins over a transfer in the same cycle
      duty_pending <= wr_duty || (duty_pending && !duty_now);
      override_pending <= wr_ovr || (override_pending && !ovr_now);
      if (duty_now) begin
        duty_active <= duty_buffer;
      end
      if (timebase_period_match && !ub) begin
        period_active <= period_buffer;
      end
      if (ovr_now) begin
        override_pins <= override_control_reg;
      end
    end
  end

  // ****************************************
  // Special event trigger
  // ****************************************
  // Count change detection keeps one event per match, even if time base stalls
  wire logic raw_trigger = (pwm_timebase_count != prev_timebase) &&
      (pwm_timebase_count[14:0] == trigger_compare_value[14:0]) &&
      (pwm_timebase_count[15] == trigger_compare_value[15]);
  wire logic post_hit = (post_cnt >= pwm_update_control.postscale);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      prev_timebase <= reg_reset;
      post_cnt <= 4'h0;
      special_event_trigger <= 1'b0;
    end else begin
      prev_timebase <= pwm_timebase_count;
      special_event_trigger <= raw_trigger && post_hit;
      if (raw_trigger) begin
        post_cnt <= post_hit ? 4'h0 : post_cnt + 4'h1;
      end
    end
  end

  // ****************************************
  // Dead-time units
  // ****************************************
  deadtime_unit #(.tcy_div(tcy_div)) unit_a (
    .clk(clk),
    .nrst(nrst),
    .tcy_tick(tcy_tick),
    .cfg(deadtime_a),
    .start(deadtime_a_start),
    .busy(deadtime_a_busy)
  );

  deadtime_unit #(.tcy_div(tcy_div)) unit_b (
    .clk(clk),
    .nrst(nrst),
    .tcy_tick(tcy_tick),
    .cfg(deadtime_b),
    .start(deadtime_b_start),
    .busy(deadtime_b_busy)
  );

endmodule : pwm_update_ctrl
`default_nettype wire

// ===== verif/switch_model.sv
`timescale 1ns/10ps
`default_nettype none
// ****
// Power switch stage
// ****
module switch_model (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [15:0] gate_drive,
  output logic [15:0] switch_state
);
  // Switches follow the gate one clock late
  always_ff @(posedge clk) begin
    if (!nrst) begin
      switch_state <= 16'h0000;
    end else begin
      switch_state <= gate_drive;
    end
  end
endmodule : switch_model
`default_nettype wire

// ===== verif/pwm_update_checker.sv
`timescale 1ns/10ps
`default_nettype none
// ****
// Port checks
// ****
module pwm_update_checker
  import pwm_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic timebase_period_match,
  input wire logic special_event_trigger,
  input wire logic [15:0] duty_active,
  input wire logic [15:0] period_active,
  input wire logic [15:0] override_pins
);
  logic [2:0] ctl;
  logic [15:0] last_wd;
  wire wr0 = avs_write && avs_address == addr_update_control;
  wire done_rd = avs_read && !avs_waitrequest;
  wire full = avs_write && avs_byteenable == 4'h3;
  // Shadow of control bits, so checks see the mode in force
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ctl <= 3'h0;
    end else if (wr0 && avs_byteenable[0]) begin
      ctl <= avs_writedata[2:0];
    end
  end
  always_ff @(posedge clk) begin
    if (avs_write) begin
      last_wd <= avs_writedata[15:0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence rd_answer;
    avs_waitrequest ##1 !avs_waitrequest;
  endsequence
  write_no_wait_a: assert property (avs_write |-> !avs_waitrequest)
    else $error("write stalled");
  read_one_wait_a: assert property (avs_read && !$past(avs_read) |-> rd_answer)
    else $error("read wait wrong");
  unmapped_zero_a: assert property (done_rd && avs_address > addr_deadtime_stat
    |-> avs_readdata == 32'h0000_0000) else $error("unmapped not zero");
  unimpl_zero_a: assert property (done_rd && avs_address == addr_update_control
    |-> (avs_readdata & ~{16'h0000, update_control_mask}) == 32'h0000_0000)
    else $error("unused bits set");
  trig_pulse_a: assert property (special_event_trigger |=> !special_event_trigger)
    else $error("trigger too long");
  block_hold_a: assert property (ctl[0] && timebase_period_match
    |=> $stable(period_active) && $stable(duty_active))
    else $error("blocked update moved");
  ovr_tcy_a: assert property (full && avs_address == addr_override && !ctl[1]
    |-> ##[1:3] override_pins == last_wd) else $error("override late");
  ovr_sync_a: assert property (ctl[1] && !timebase_period_match
    |=> $stable(override_pins)) else $error("override unsynced");
  imm_duty_a: assert property (full && avs_address == addr_duty_buffer
    && ctl[2] && !ctl[0] |-> ##[1:2] duty_active == last_wd)
    else $error("immediate duty late");
endmodule : pwm_update_checker
bind pwm_update_ctrl pwm_update_checker i_chk (.clk(clk), .nrst(nrst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .timebase_period_match(timebase_period_match),
  .special_event_trigger(special_event_trigger), .duty_active(duty_active),
  .period_active(period_active), .override_pins(override_pins));
`default_nettype wire

// ===== verif/testbench.sv
`timescale 1ns/10ps
`default_nettype none
// ****
// Register level tests
// ****
module testbench;
  import pwm_ctrl_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0] avs_byteenable = 4'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [15:0] pwm_timebase_count = 16'h0000;
  logic period_match = 1'b0;
  logic start_a = 1'b0;
  logic start_b = 1'b0;
  logic trig;
  logic [15:0] duty_active;
  logic [15:0] period_active;
  logic [15:0] override_pins;
  logic [15:0] switch_state;
  logic busy_a;
  logic busy_b;
  logic [31:0] d;
  int bad_count = 0;
  int compares = 0;
  int trig_n = 0;
  int n;
  int k;
  always #2.5 clk = ~clk;
  always @(posedge clk) if (trig === 1'b1) trig_n <= trig_n + 1;
  pwm_update_ctrl i_pwm_update_ctrl (.clk(clk), .nrst(nrst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .pwm_timebase_count(pwm_timebase_count),
    .timebase_period_match(period_match), .deadtime_a_start(start_a),
    .deadtime_b_start(start_b), .special_event_trigger(trig),
    .duty_active(duty_active), .period_active(period_active),
    .override_pins(override_pins), .deadtime_a_busy(busy_a),
    .deadtime_b_busy(busy_b));
  switch_model i_switch_model (.clk(clk), .nrst(nrst),
    .gate_drive(override_pins), .switch_state(switch_state));
  task final_report;
    $display("compares %0d errors %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : final_report
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      bad_count++;
    end
  endtask : chk
  // Request held until waitrequest is seen low at an edge
  task bus(input logic w, input logic [3:0] a, input logic [15:0] v);
    int i;
    i = 0;
    avs_address <= a;
    avs_writedata <= {16'h0000, v};
    avs_byteenable <= 4'h3;
    avs_write <= w;
    avs_read <= !w;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0 && i < 20) begin
      @(posedge clk);
      i++;
    end
    d = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (i >= 20) begin
      bad_count++;
      final_report;
    end
    @(posedge clk);
  endtask : bus
  task wr(input logic [3:0] a, input logic [15:0] v);
    bus(1'b1, a, v);
  endtask : wr
  task rc(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 16'h0000);
    chk("readdata", e, d);
  endtask : rc
  task match;
    period_match <= 1'b1;
    @(posedge clk);
    period_match <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : match
  task ev(input logic [15:0] v);
    pwm_timebase_count <= v;
    @(posedge clk);
    pwm_timebase_count <= 16'h0000;
    @(posedge clk);
  endtask : ev
  // Start can land late in a Tcy, so one clock less is allowed
  task dt(input int ps, input int ca, input int cb);
    int ta, tb, ea, eb, i;
    ea = (ca << ps) * tcy_cycles;
    eb = (cb << ps) * tcy_cycles;
    ta = 0;
    tb = 0;
    wr(addr_deadtime_config, 16'((ps << 14) | (cb << 8) | (ps << 6) | ca));
    start_a <= 1'b1;
    start_b <= 1'b1;
    @(posedge clk);
    start_a <= 1'b0;
    start_b <= 1'b0;
    for (i = 0; i < 200; i++) begin
      @(posedge clk);
      if (busy_a === 1'b1) ta++;
      if (busy_b === 1'b1) tb++;
    end
    chk($sformatf("busy a %0d", ta), 1, ta >= ea - 1 && ta <= ea);
    chk($sformatf("busy b %0d", tb), 1, tb >= eb - 1 && tb <= eb);
  endtask : dt
  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rc(addr_update_control, 32'h0000_0000);
    rc(addr_deadtime_config, 32'h0000_0000);
    rc(4'hf, 32'h0000_0000);
    wr(addr_update_control, 16'hffff);
    rc(addr_update_control, 32'h0000_0f07);
    wr(addr_deadtime_config, 16'hffff);
    rc(addr_deadtime_config, 32'h0000_ffff);
    wr(addr_trigger_compare, 16'h0005);
    rc(addr_trigger_compare, 32'h0000_0005);
    for (k = 0; k < 16; k++) begin
      wr(addr_update_control, 16'(k << 8));
      n = trig_n;
      repeat (2 * (k + 1)) ev(16'h0005);
      ev(16'h8005);
      repeat (2) @(posedge clk);
      chk("trigger count", 2, trig_n - n);
    end
    wr(addr_update_control, 16'h0000);
    wr(addr_trigger_compare, 16'h8005);
    n = trig_n;
    ev(16'h8005);
    ev(16'h0005);
    repeat (2) @(posedge clk);
    chk("trigger down", 1, trig_n - n);
    wr(addr_duty_buffer, 16'h1234);
    repeat (4) @(posedge clk);
    chk("duty held", 0, duty_active);
    match;
    chk("duty synced", 16'h1234, duty_active);
    wr(addr_update_control, 16'h0004);
    wr(addr_duty_buffer, 16'h5678);
    repeat (2) @(posedge clk);
    chk("duty immediate", 16'h5678, duty_active);
    rc(addr_duty_active, 32'h0000_5678);
    wr(addr_update_control, 16'h0001);
    wr(addr_period_buffer, 16'h00aa);
    wr(addr_duty_buffer, 16'h00bb);
    match;
    chk("period blocked", 0, period_active);
    chk("duty blocked", 16'h5678, duty_active);
    rc(addr_status, 32'h0000_0001);
    wr(addr_update_control, 16'h0000);
    match;
    chk("period loaded", 16'h00aa, period_active);
    chk("duty loaded", 16'h00bb, duty_active);
    rc(addr_deadtime_stat, 32'h0000_00aa);
    wr(addr_override, 16'h00c3);
    repeat (4) @(posedge clk);
    chk("override tcy", 16'h00c3, override_pins);
    chk("switches", 16'h00c3, switch_state);
    wr(addr_update_control, 16'h0002);
    wr(addr_override, 16'h003c);
    repeat (4) @(posedge clk);
    chk("override held", 16'h00c3, override_pins);
    match;
    chk("override synced", 16'h003c, override_pins);
    for (k = 0; k < 4; k++) dt(k, 3, 5);
    final_report;
  end
endmodule : testbench
`default_nettype wire
